// ### hw/lmr_pkg.sv
package lmr_pkg;
   // register codes
   localparam logic [3:0] REG_CHAIN_POSITION = 4'h0;
   localparam logic [3:0] REG_PIXEL_SCALE_SELECT = 4'h1;
   localparam logic [3:0] REG_PANEL_BRIGHTNESS = 4'h2;
   localparam logic [3:0] REG_TILE0_BRIGHTNESS = 4'h3;
   localparam logic [3:0] REG_TILE1_BRIGHTNESS = 4'h4;
   localparam logic [3:0] REG_LED_FAULT_FLAGS = 4'h5;
   localparam logic [3:0] REG_TARGET_DRIVER_POINTER = 4'h8;
   localparam logic [3:0] REG_MEMORY_POINTER_LOW = 4'h9;
   localparam logic [3:0] REG_MEMORY_POINTER_HIGH = 4'hA;
   localparam logic [3:0] REG_PLANE_SEQUENCER = 4'hB;
   localparam logic [3:0] REG_PANEL_SETUP = 4'hD;
   localparam logic [3:0] REG_CHAIN_LENGTH_MINUS_ONE = 4'hE;
   localparam logic [3:0] REG_ROW_WIDTH_MINUS_ONE = 4'hF;
   // reset values
   localparam logic [7:0] RST_CHAIN_POSITION = 8'h00;
   localparam logic [7:0] RST_PIXEL_SCALE_SELECT = 8'h00;
   localparam logic [7:0] RST_PANEL_BRIGHTNESS = 8'h80;
   localparam logic [7:0] RST_TILE_BRIGHTNESS = 8'hFF;
   localparam logic [7:0] RST_LED_FAULT_FLAGS = 8'h00;
   localparam logic [7:0] RST_POINTER = 8'h00;
   localparam logic [7:0] RST_PLANE_SEQUENCER = 8'h00;
   localparam logic [7:0] RST_PANEL_SETUP = 8'h30;
   localparam logic [7:0] RST_COUNT = 8'hFF;
   // panel setup field positions
   localparam int SETUP_RUN = 0;
   localparam int SETUP_POLARITY = 1;
   localparam int SETUP_PLANE_LO = 2;
   localparam int SETUP_PLANE_HI = 3;
   localparam int SETUP_RIPPLE = 4;
   localparam int SETUP_FLIP = 5;
   localparam int SETUP_COLOUR = 6;
   localparam int SETUP_DEPTH = 7;
   // framing and timing
   localparam logic [4:0] CMD_BITS = 5'h10;
   localparam logic [3:0] READ_BITS = 4'h8;
   localparam int START_DELAY_OSC_CYCLES = 2097152;
   localparam int CHAIN_DIVIDE = 4;
   localparam int CHAIN_PERIODS = 256;
   localparam int ASSIGN_CYCLES = CHAIN_DIVIDE * CHAIN_PERIODS;

   // one 16-bit command as it arrives, first bit in the top
   typedef struct packed {
      logic read;
      logic autoinc;
      logic broadcast;
      logic spare;
      logic [3:0] code;
      logic [7:0] data;
   } lmr_cmd_type;

   typedef enum logic [3:0] {
      ST_HOLD = 4'h1,
      ST_DELAY = 4'h2,
      ST_ASSIGN = 4'h4,
      ST_READY = 4'h8
   } lmr_state_type;
endpackage

// ### hw/lmr_top.sv
`timescale 1ns/100ps
module lmr_top #(
   parameter int START_DELAY_CYCLES = lmr_pkg::START_DELAY_OSC_CYCLES
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic ext_reset_n_in,
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic din_in,
   output logic dout_out,
   output logic dout_oe_out,
   input wire logic chain_in,
   output logic chain_out,
   output logic chain_clock_out,
   output logic chain_clock_oe_out,
   input wire logic pixel_bit_in,
   output logic led_on_out,
   output logic shutdown_out,
   output logic [1:0] plane_select_out,
   output logic plane_depth_mode_out,
   output logic colour_mode_out,
   output logic flip_out,
   output logic ripple_out,
   output logic [7:0] panel_brightness_out,
   output logic [7:0] tile0_brightness_out,
   output logic [7:0] tile1_brightness_out,
   output logic [7:0] chain_position_out,
   output logic assign_busy_out
);
   localparam int DW = $clog2(START_DELAY_CYCLES + 1);
   localparam logic [DW-1:0] DELAY_LAST = DW'(START_DELAY_CYCLES - 1);
   localparam logic [9:0] ASSIGN_LAST = 10'(lmr_pkg::ASSIGN_CYCLES - 1);

   logic [1:0] cs_sync_reg, sclk_sync_reg, din_sync_reg, ext_sync_reg, chain_sync_reg;
   logic cs_last_reg, sclk_last_reg;
   logic [15:0] shift_reg;
   logic [4:0] bit_cnt_reg;
   logic exec;
   lmr_pkg::lmr_cmd_type cmd;
   lmr_pkg::lmr_state_type state_reg;
   logic [DW-1:0] delay_reg;
   logic [9:0] assign_cnt_reg;
   logic [7:0] period;
   logic master_reg, found_reg;
   logic [7:0] position_reg, pointer_reg, scale_reg, panel_reg, tile0_reg, tile1_reg;
   logic [7:0] fault_reg, mem_lo_reg, mem_hi_reg, plane_seq_reg, setup_reg;
   logic [7:0] length_reg, rows_reg;
   logic [7:0] rd_shift_reg;
   logic [3:0] rd_cnt_reg;
   logic rd_oe_reg;
   logic is_local, hit_self, wr_en, rd_sel, assign_done, setup_written;
   logic sclk_rise, sclk_fall, cs_rise, cs_fall;

   // read mux shared by the readback loader
   function automatic logic [7:0] reg_read(input logic [3:0] code);
      case (code)
         lmr_pkg::REG_CHAIN_POSITION: reg_read = position_reg;
         lmr_pkg::REG_PIXEL_SCALE_SELECT: reg_read = scale_reg;
         lmr_pkg::REG_PANEL_BRIGHTNESS: reg_read = panel_reg;
         lmr_pkg::REG_TILE0_BRIGHTNESS: reg_read = tile0_reg;
         lmr_pkg::REG_TILE1_BRIGHTNESS: reg_read = tile1_reg;
         lmr_pkg::REG_LED_FAULT_FLAGS: reg_read = fault_reg;
         lmr_pkg::REG_TARGET_DRIVER_POINTER: reg_read = pointer_reg;
         lmr_pkg::REG_MEMORY_POINTER_LOW: reg_read = mem_lo_reg;
         lmr_pkg::REG_MEMORY_POINTER_HIGH: reg_read = mem_hi_reg;
         lmr_pkg::REG_PLANE_SEQUENCER: reg_read = plane_seq_reg;
         lmr_pkg::REG_PANEL_SETUP: reg_read = setup_reg;
         lmr_pkg::REG_CHAIN_LENGTH_MINUS_ONE: reg_read = length_reg;
         lmr_pkg::REG_ROW_WIDTH_MINUS_ONE: reg_read = rows_reg;
         default: reg_read = 8'h00;
      endcase
   endfunction

   // pins cross into the oscillator domain through two flops each
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         cs_sync_reg <= 2'h3;
         sclk_sync_reg <= 2'h0;
         din_sync_reg <= 2'h0;
         ext_sync_reg <= 2'h0;
         chain_sync_reg <= 2'h0;
         cs_last_reg <= 1'b1;
         sclk_last_reg <= 1'b0;
      end else begin
         cs_sync_reg <= {cs_sync_reg[0], cs_n_in};
         sclk_sync_reg <= {sclk_sync_reg[0], sclk_in};
         din_sync_reg <= {din_sync_reg[0], din_in};
         ext_sync_reg <= {ext_sync_reg[0], ext_reset_n_in};
         chain_sync_reg <= {chain_sync_reg[0], chain_in};
         cs_last_reg <= cs_sync_reg[1];
         sclk_last_reg <= sclk_sync_reg[1];
      end
   end

   assign sclk_rise = sclk_sync_reg[1] & ~sclk_last_reg;
   assign sclk_fall = ~sclk_sync_reg[1] & sclk_last_reg;
   assign cs_rise = cs_sync_reg[1] & ~cs_last_reg;
   assign cs_fall = ~cs_sync_reg[1] & cs_last_reg;

   // command shifter; anything but exactly 16 bits is dropped at select release
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         shift_reg <= 16'h0000;
         bit_cnt_reg <= 5'h00;
      end else if (cs_fall) begin
         bit_cnt_reg <= 5'h00;
      end else if (sclk_rise && !cs_sync_reg[1]) begin
         shift_reg <= {shift_reg[14:0], din_sync_reg[1]};
         if (bit_cnt_reg != 5'h1F) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
         end
      end
   end

   // decode of a completed command
   always_comb begin
      cmd = lmr_pkg::lmr_cmd_type'(shift_reg);
      exec = cs_rise && (bit_cnt_reg == lmr_pkg::CMD_BITS);
      is_local = ~cmd.code[3];
      hit_self = (pointer_reg == position_reg);
      // global codes and global-flagged local writes land everywhere
      wr_en = exec && !cmd.read && (!is_local || cmd.broadcast || hit_self);
      // reads are refused while the chain is being numbered
      rd_sel = exec && cmd.read && (state_reg != lmr_pkg::ST_ASSIGN) &&
         (is_local ? hit_self : (position_reg == 8'h00));
      setup_written = wr_en && (cmd.code == lmr_pkg::REG_PANEL_SETUP);
   end

   // driver pointer: host writes it, local accesses may bump it in every driver
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         pointer_reg <= lmr_pkg::RST_POINTER;
      end else if (wr_en && cmd.code == lmr_pkg::REG_TARGET_DRIVER_POINTER) begin
         pointer_reg <= cmd.data;
      end else if (exec && is_local && cmd.autoinc) begin
         pointer_reg <= pointer_reg + 8'h01;
      end
   end

   // plain read/write registers, loaded at power-on reset only
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         scale_reg <= lmr_pkg::RST_PIXEL_SCALE_SELECT;
         panel_reg <= lmr_pkg::RST_PANEL_BRIGHTNESS;
         tile0_reg <= lmr_pkg::RST_TILE_BRIGHTNESS;
         tile1_reg <= lmr_pkg::RST_TILE_BRIGHTNESS;
         fault_reg <= lmr_pkg::RST_LED_FAULT_FLAGS;
         mem_lo_reg <= lmr_pkg::RST_POINTER;
         mem_hi_reg <= lmr_pkg::RST_POINTER;
         plane_seq_reg <= lmr_pkg::RST_PLANE_SEQUENCER;
         length_reg <= lmr_pkg::RST_COUNT;
         rows_reg <= lmr_pkg::RST_COUNT;
      end else if (wr_en) begin
         case (cmd.code)
            lmr_pkg::REG_PIXEL_SCALE_SELECT: scale_reg <= cmd.data;
            lmr_pkg::REG_PANEL_BRIGHTNESS: panel_reg <= cmd.data;
            lmr_pkg::REG_TILE0_BRIGHTNESS: tile0_reg <= cmd.data;
            lmr_pkg::REG_TILE1_BRIGHTNESS: tile1_reg <= cmd.data;
            lmr_pkg::REG_LED_FAULT_FLAGS: fault_reg <= cmd.data;
            lmr_pkg::REG_MEMORY_POINTER_LOW: mem_lo_reg <= cmd.data;
            lmr_pkg::REG_MEMORY_POINTER_HIGH: mem_hi_reg <= cmd.data;
            lmr_pkg::REG_PLANE_SEQUENCER: plane_seq_reg <= cmd.data;
            lmr_pkg::REG_CHAIN_LENGTH_MINUS_ONE: length_reg <= cmd.data;
            lmr_pkg::REG_ROW_WIDTH_MINUS_ONE: rows_reg <= cmd.data;
            default: ;
         endcase
      end
   end

   // panel setup; finishing assignment forces shutdown, a host write in that cycle loses
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         setup_reg <= lmr_pkg::RST_PANEL_SETUP;
      end else if (assign_done) begin
         setup_reg[lmr_pkg::SETUP_RUN] <= 1'b0;
      end else if (setup_written) begin
         setup_reg <= cmd.data;
      end
   end

   // start-up sequencer: hold in external reset, wait, then number the chain
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         state_reg <= lmr_pkg::ST_HOLD;
         delay_reg <= '0;
      end else if (!ext_sync_reg[1]) begin
         state_reg <= lmr_pkg::ST_HOLD;
         delay_reg <= '0;
      end else begin
         case (state_reg)
            lmr_pkg::ST_HOLD: begin
               state_reg <= lmr_pkg::ST_DELAY;
            end
            lmr_pkg::ST_DELAY: begin
               delay_reg <= delay_reg + DW'(1);
               if (delay_reg == DELAY_LAST) begin
                  state_reg <= lmr_pkg::ST_ASSIGN;
               end
            end
            lmr_pkg::ST_ASSIGN: begin
               if (assign_done) begin
                  state_reg <= lmr_pkg::ST_READY;
               end
            end
            lmr_pkg::ST_READY: begin
               // a new panel setup renumbers the chain
               if (setup_written) begin
                  state_reg <= lmr_pkg::ST_ASSIGN;
               end
            end
            default: state_reg <= lmr_pkg::ST_HOLD;
         endcase
      end
   end

   assign period = assign_cnt_reg[9:2];
   assign assign_done = (state_reg == lmr_pkg::ST_ASSIGN) && (assign_cnt_reg == ASSIGN_LAST);

   // chain numbering: count quarter-rate periods until the upstream line goes high
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         assign_cnt_reg <= 10'h000;
         position_reg <= lmr_pkg::RST_CHAIN_POSITION;
         master_reg <= 1'b0;
         found_reg <= 1'b0;
      end else if (state_reg != lmr_pkg::ST_ASSIGN) begin
         assign_cnt_reg <= 10'h000;
      end else begin
         assign_cnt_reg <= assign_cnt_reg + 10'h001;
         if (assign_cnt_reg == 10'h000) begin
            // an upstream line already high marks the chain head
            master_reg <= chain_sync_reg[1];
            found_reg <= chain_sync_reg[1];
            position_reg <= 8'h00;
         end else if (!found_reg && chain_sync_reg[1]) begin
            found_reg <= 1'b1;
            // the sender's register and our two sync flops put its rise one period late
            position_reg <= period - 8'h01;
         end else if (!found_reg && assign_done) begin
            position_reg <= period; // upstream never rose: take the last slot
         end
      end
   end

   // downstream line rises position + 1.5 chain periods after the start
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         chain_out <= 1'b0;
         chain_clock_out <= 1'b0;
         chain_clock_oe_out <= 1'b0;
      end else if (state_reg == lmr_pkg::ST_ASSIGN) begin
         // visible 4 * position + 6 clocks in; 11 bits so the last slot cannot wrap
         chain_out <= found_reg && ({1'b0, assign_cnt_reg} >= {1'b0, position_reg, 2'h0} + 11'h005);
         chain_clock_out <= assign_cnt_reg[1];
         chain_clock_oe_out <= master_reg;
      end else begin
         chain_out <= (state_reg == lmr_pkg::ST_READY) && found_reg;
         chain_clock_out <= 1'b0;
         chain_clock_oe_out <= 1'b0;
      end
   end

   // readback: hold the data line from select release through eight clock bits
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         rd_shift_reg <= 8'h00;
         rd_cnt_reg <= 4'h0;
         rd_oe_reg <= 1'b0;
      end else if (rd_sel) begin
         rd_shift_reg <= reg_read(cmd.code);
         rd_cnt_reg <= 4'h0;
         rd_oe_reg <= 1'b1;
      end else if (rd_oe_reg) begin
         if (cs_fall) begin
            rd_oe_reg <= 1'b0; // a new frame always wins the line back
         end else if (sclk_rise) begin
            rd_cnt_reg <= rd_cnt_reg + 4'h1;
         end else if (sclk_fall && rd_cnt_reg != 4'h0) begin
            if (rd_cnt_reg == lmr_pkg::READ_BITS) begin
               rd_oe_reg <= 1'b0;
            end else begin
               rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
            end
         end
      end
   end

   assign dout_out = rd_shift_reg[7];
   assign dout_oe_out = rd_oe_reg;

   // panel controls handed to the multiplexer
   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         led_on_out <= 1'b0;
         plane_select_out <= 2'h0;
      end else begin
         led_on_out <= pixel_bit_in ^ setup_reg[lmr_pkg::SETUP_POLARITY];
         plane_select_out <= {setup_reg[lmr_pkg::SETUP_PLANE_HI] &
            ~setup_reg[lmr_pkg::SETUP_DEPTH], setup_reg[lmr_pkg::SETUP_PLANE_LO]};
      end
   end

   assign shutdown_out = ~setup_reg[lmr_pkg::SETUP_RUN];
   assign plane_depth_mode_out = setup_reg[lmr_pkg::SETUP_DEPTH];
   assign colour_mode_out = setup_reg[lmr_pkg::SETUP_COLOUR];
   assign flip_out = setup_reg[lmr_pkg::SETUP_FLIP];
   assign ripple_out = setup_reg[lmr_pkg::SETUP_RIPPLE];
   assign panel_brightness_out = panel_reg;
   assign tile0_brightness_out = tile0_reg;
   assign tile1_brightness_out = tile1_reg;
   assign chain_position_out = position_reg;
   assign assign_busy_out = (state_reg == lmr_pkg::ST_ASSIGN);
endmodule // lmr_top

// ### verif/lmr_assertions.sv
`timescale 1ns/100ps
module lmr_assertions (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic ext_reset_n_in,
   input wire logic cs_n_in,
   input wire logic dout_oe_out,
   input wire logic shutdown_out,
   input wire logic [1:0] plane_select_out,
   input wire logic plane_depth_mode_out,
   input wire logic ripple_out,
   input wire logic [7:0] panel_brightness_out,
   input wire logic assign_busy_out,
   input wire logic chain_clock_out
);
   // one clock domain, so clock and reset are given once
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);
   // chain clock rise in a quiet stretch of an assignment; a restart may re-phase it
   sequence s_chain_rise;
      $rose(chain_clock_out) && assign_busy_out && $past(cs_n_in, 8) ##4 assign_busy_out && cs_n_in;
   endsequence
   // select held low long enough to pass the synchroniser
   sequence s_cs_low;
      (!cs_n_in) [*5];
   endsequence
   property p_por;
      $fell(reset_in) |-> panel_brightness_out == 8'h80 && shutdown_out && ripple_out;
   endproperty
   property p_run_from_write;
      $fell(shutdown_out) |-> cs_n_in && !$past(cs_n_in, 8);
   endproperty
   property p_plane_fold;
      plane_depth_mode_out && $past(plane_depth_mode_out) |-> !plane_select_out[1];
   endproperty
   property p_hold_in_reset;
      (!ext_reset_n_in) [*4] |-> !assign_busy_out;
   endproperty
   property p_chain_rate;
      s_chain_rise |-> $rose(chain_clock_out);
   endproperty
   property p_sleep_after;
      $fell(assign_busy_out) |-> ##[0:2] shutdown_out;
   endproperty
   property p_no_read_busy;
      $rose(dout_oe_out) |-> cs_n_in && !$past(assign_busy_out);
   endproperty
   property p_release_in_frame;
      s_cs_low |-> !dout_oe_out;
   endproperty
   a_por: assert property (p_por)
      else $error("power-up values wrong");
   a_run_from_write: assert property (p_run_from_write)
      else $error("run entered without a write");
   a_plane_fold: assert property (p_plane_fold)
      else $error("plane above 1 in two-bit mode");
   a_hold_in_reset: assert property (p_hold_in_reset)
      else $error("assigning while external reset low");
   a_chain_rate: assert property (p_chain_rate)
      else $error("chain clock not a quarter rate");
   a_sleep_after: assert property (p_sleep_after)
      else $error("no shutdown after assignment");
   a_no_read_busy: assert property (p_no_read_busy)
      else $error("read answered while assigning");
   a_release_in_frame: assert property (p_release_in_frame)
      else $error("data line held into a new frame");
endmodule // lmr_assertions

bind lmr_top lmr_assertions u_lmr_chk (
   .clk_in(clk_in), .reset_in(reset_in), .ext_reset_n_in(ext_reset_n_in), .cs_n_in(cs_n_in),
   .dout_oe_out(dout_oe_out), .shutdown_out(shutdown_out), .plane_select_out(plane_select_out),
   .plane_depth_mode_out(plane_depth_mode_out), .ripple_out(ripple_out),
   .panel_brightness_out(panel_brightness_out), .assign_busy_out(assign_busy_out),
   .chain_clock_out(chain_clock_out)
);

// ### verif/lmr_host_model.sv
`timescale 1ns/100ps
module lmr_host_model (
   input wire logic clk_in,
   input wire logic dout_in,
   input wire logic dout_oe_in,
   output logic cs_n_out,
   output logic sclk_out,
   output logic din_out
);
   logic last_bit = 1'b0;
   logic line;
   // a released data line toggles, so a stale bit never reads as valid
   assign line = dout_oe_in ? dout_in : ~last_bit;
   always @(posedge clk_in) begin
      last_bit <= line;
   end
   // idle bus levels from time zero
   initial begin
      cs_n_out = 1'b1;
      sclk_out = 1'b0;
      din_out = 1'b0;
   end
   // four system clocks per serial phase, the least the sampler accepts
   task automatic half();
      repeat (4) @(posedge clk_in);
   endtask
   // one 16-bit frame top bit first, then eight bits back on a read
   task automatic xfer(input logic [15:0] cmd, output logic [7:0] rd, output logic ans);
      rd = 8'h00;
      cs_n_out <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         din_out <= cmd[i];
         half();
         sclk_out <= 1'b1;
         half();
         if (i > 0) begin
            sclk_out <= 1'b0;
         end
      end
      cs_n_out <= 1'b1; // raised while the serial clock is still high
      half();
      sclk_out <= 1'b0;
      repeat (6) @(posedge clk_in);
      ans = dout_oe_in;
      if (cmd[15]) begin
         for (int i = 0; i < 8; i++) begin
            rd = {rd[6:0], line};
            sclk_out <= 1'b1;
            half();
            sclk_out <= 1'b0;
            half();
         end
      end
   endtask
endmodule // lmr_host_model

// ### verif/led_matrix_reg_addressing_tb_top.sv
`timescale 1ns/100ps
module led_matrix_reg_addressing_tb_top;
   localparam int SD = 400;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic ext_reset_n = 1'b0;
   logic pixel = 1'b0;
   logic chain = 1'b1;
   logic chain_o, ck_oe;
   logic cs_n, sclk, din, dout, dout_oe, led_on, shutdown, depth, colour, flip, ripple, busy, ans;
   logic [1:0] plane;
   logic [7:0] pb, t0, t1, pos, rd, s;
   int errors = 0;
   int check_count = 0;
   int cycles = 0;
   int n;
   logic [7:0] setups [0:6] = '{8'h01, 8'h06, 8'h08, 8'h0E, 8'h88, 8'h8D, 8'h71};
   lmr_top #(.START_DELAY_CYCLES(SD)) dut (
      .clk_in(clk_in), .reset_in(reset_in), .ext_reset_n_in(ext_reset_n), .cs_n_in(cs_n),
      .sclk_in(sclk), .din_in(din), .dout_out(dout), .dout_oe_out(dout_oe), .chain_in(chain),
      .chain_out(chain_o), .chain_clock_out(), .chain_clock_oe_out(ck_oe), .pixel_bit_in(pixel),
      .led_on_out(led_on), .shutdown_out(shutdown), .plane_select_out(plane),
      .plane_depth_mode_out(depth), .colour_mode_out(colour), .flip_out(flip),
      .ripple_out(ripple), .panel_brightness_out(pb), .tile0_brightness_out(t0),
      .tile1_brightness_out(t1), .chain_position_out(pos), .assign_busy_out(busy)
   );
   lmr_host_model host (
      .clk_in(clk_in), .dout_in(dout), .dout_oe_in(dout_oe), .cs_n_out(cs_n),
      .sclk_out(sclk), .din_out(din)
   );
   // 100 MHz system clock
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done();
      if (errors == 0 && check_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic wr(input logic [7:0] hi, input logic [7:0] d);
      host.xfer({hi, d}, rd, ans);
   endtask
   // a read either answered with exp or left on a released line
   task automatic rdchk(input logic [7:0] hi, input logic [7:0] exp, input logic ok);
      host.xfer({hi, 8'h00}, rd, ans);
      check(16'(ans), 16'(ok));
      if (ok) begin
         check(16'(rd), 16'(exp));
      end
   endtask
   // bounded wait for the assignment flag to reach a level
   task automatic wait_busy(input logic lvl);
      n = 0;
      while (busy !== lvl && n < 5000) begin
         @(posedge clk_in);
         n++;
      end
   endtask
   // a hang ends the run as a failure
   always @(posedge clk_in) begin
      cycles++;
      if (cycles == 30000) begin
         errors++;
         test_done();
      end
   end
   // main sequence
   initial begin
      repeat (8) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      check({pb, t0}, 16'h80FF);
      check(16'({t1, shutdown, depth, colour, flip, ripple, plane}), 16'h7FCC);
      repeat (3) @(posedge clk_in); // external reset held past the synchroniser
      ext_reset_n <= 1'b1;
      fork
         begin
            wait_busy(1'b1);
            check(16'(n >= SD && n <= SD + 8), 16'h0001);
            wait_busy(1'b0);
            check(16'(n), 16'h0400);
         end
         begin
            wr(8'h0F, 8'h05);
            wr(8'h0E, 8'h17);
         end
         begin
            // the chain head drives the chain clock once numbering starts
            @(posedge busy);
            repeat (4) @(posedge clk_in);
            check(16'(ck_oe), 16'h0001);
         end
      join
      repeat (3) @(posedge clk_in);
      check(16'({shutdown, pos}), 16'h0100);
      check(16'(chain_o), 16'h0001);
      rdchk(8'h80, 8'h00, 1'b1);
      rdchk(8'h8F, 8'h05, 1'b1);
      wr(8'h02, 8'h5A);
      wr(8'h08, 8'h01);
      wr(8'h02, 8'h33); // pointer now names another driver
      check(16'(pb), 16'h005A);
      rdchk(8'hA2, 8'h00, 1'b0);
      wr(8'h22, 8'h33);
      wr(8'h63, 8'h11);
      check({pb, t0}, 16'h3311);
      wr(8'h7B, 8'h00); // global code ignores the bump bit
      rdchk(8'h88, 8'h02, 1'b1);
      wr(8'h08, 8'hFF);
      wr(8'h44, 8'h22); // unselected, pointer wraps to zero
      check(16'(t1), 16'h00FF);
      rdchk(8'hC2, 8'h33, 1'b1);
      rdchk(8'h82, 8'h00, 1'b0);
      wr(8'h08, 8'h00);
      wr(8'h20, 8'h55);
      rdchk(8'h80, 8'h00, 1'b1);
      rdchk(8'h84, 8'hFF, 1'b1);
      // every plane code with depth clear and the upper two with depth set, with both pixel polarities
      foreach (setups[i]) begin
         s = setups[i];
         pixel <= i[0];
         wr(8'h0D, s);
         check(16'(plane), 16'((s[7] && s[3]) ? {1'b0, s[2]} : s[3:2]));
         check(16'({depth, colour, flip, ripple, led_on, shutdown}),
               16'({s[7:4], pixel ^ s[1], ~s[0]}));
      end
      rdchk(8'h80, 8'h00, 1'b0);
      wait_busy(1'b0);
      repeat (3) @(posedge clk_in);
      check(16'(shutdown), 16'h0001);
      // renumber behind driver 2: its line rises 1.5 periods past its slot, a clock late here
      chain <= 1'b0;
      wr(8'h0D, 8'h30);
      check(16'({busy, ck_oe}), 16'h0002);
      repeat (8) @(posedge clk_in);
      chain <= 1'b1;
      wait_busy(1'b0);
      repeat (3) @(posedge clk_in);
      check(16'({chain_o, pos}), 16'h0103);
      rdchk(8'h8F, 8'h05, 1'b0);
      rdchk(8'h80, 8'h03, 1'b0);
      wr(8'h08, 8'h03);
      rdchk(8'h80, 8'h03, 1'b1);
      test_done();
   end
endmodule // led_matrix_reg_addressing_tb_top
